// ===== verilog/card_seq_pkg.sv
`default_nettype none
package card_seq_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int STEP_NS = 10000;
    localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_HOLD_NS = 102400;
    localparam int RST_HOLD_CYCLES = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int DEADLINE_MS = 5000;
    localparam int DEADLINE_CYCLES = DEADLINE_MS * CLK_MHZ * 1000;
    localparam int DEACT_STEPS = 4;
    localparam logic [5:0] CLK_DIV_HALF = 6'h20;
    // ------------------------------------------------------------
    // Status response fields
    // ------------------------------------------------------------
    localparam logic [4:0] CLASS_BYTE = 5'h0e;
    localparam int CLASS_BIT = 5;
    localparam int CLKSTOP_BIT = 0;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [12:0] {
        ST_IDLE = 13'h0001,
        ST_VCC = 13'h0002,
        ST_IO = 13'h0004,
        ST_CLK = 13'h0008,
        ST_RST = 13'h0010,
        ST_ATR = 13'h0020,
        ST_IDENT = 13'h0040,
        ST_RUN = 13'h0080,
        ST_D_RST = 13'h0100,
        ST_D_CLK = 13'h0200,
        ST_D_IO = 13'h0400,
        ST_D_VCC = 13'h0800,
        ST_FAST = 13'h1000
    } state_type;
    localparam logic [12:0] M_VCC = 13'h17fe;
    localparam logic [12:0] M_RST = 13'h00e0;
    localparam logic [12:0] M_CLK = 13'h01f8;
    localparam logic [12:0] M_IOLOW = 13'h1c03;
endpackage
`default_nettype wire

// ===== verilog/cycle_timer.sv
`default_nettype none
module cycle_timer (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic load_i,
    input wire logic stop_i,
    input wire logic [31:0] count_i,
    output logic expired_o,
    output logic running_o
);
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic run_next;
    logic exp_next;

    // ------------------------------------------------------------
    // Down counter, pulse after count_i cycles
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        run_next = running_o;
        exp_next = 1'b0;
        if (load_i) begin
            count_next = count_i;
            run_next = 1'b1;
        end else if (stop_i) begin
            run_next = 1'b0;
        end else if (running_o) begin
            if (count_reg <= 32'h0000_0001) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                count_next = count_reg - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_reg <= 32'h0000_0000;
            running_o <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            count_reg <= count_next;
            running_o <= run_next;
            expired_o <= exp_next;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/card_supply_sequencer.sv
// Contract
// R1: Only one card slot powered at any time, never two sessions together.
// R2: Contacts rise and fall in fixed order at every supply level.
// R3: Stopped clock: drop contacts in any order, all low before supply drops.
// R4: Clock restarted before deactivation: use the full ordered sequence.
// R5: Transmission protocol T=0 is mandatory, T=1 optional, on both ends.
// R6: Dual-voltage card supports clock stop and flags it in status.
// R7: Card voltage class is bit 5 of status byte 14.
// R8: Read voltage class right after answer-to-reset, before other commands.
// R9: Dual-voltage terminal activates at 5 V first, 3 V only if allowed.
// R10: Supply change finishes before any further command after identification.
// R11: A 3 V-only terminal activates directly at 3 V.
// R12: 3 V-only terminal rejects 5 V-only or failed card within 5 s.
// R13: Supply change is full deactivation then activation at new level.
// R14: Deadline counted on own clock from answer-to-reset to deactivation end.
`default_nettype none
module card_supply_sequencer #(
    parameter int RST_HOLD = card_seq_pkg::RST_HOLD_CYCLES,
    parameter int DEADLINE = card_seq_pkg::DEADLINE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic activate_i,
    input wire logic deactivate_i,
    input wire logic slot_i,
    input wire logic only_3v_i,
    input wire logic prefer_3v_i,
    input wire logic clk_stop_i,
    input wire logic atr_done_i,
    input wire logic status_valid_i,
    input wire logic [7:0] status_byte_i,
    input wire logic exchange_done_i,
    input wire logic exchange_fail_i,
    input wire logic io_tx_low_i,
    output logic [1:0] card_vcc_en_o,
    output logic card_vcc_3v_o,
    output logic card_rst_o,
    output logic card_clk_o,
    output logic card_io_o,
    output logic card_io_oe_o,
    output logic ident_phase_o,
    output logic session_ready_o,
    output logic rejected_o,
    output logic busy_o,
    output logic class_3v_o,
    output logic clk_stopped_o
);
    localparam logic [31:0] STEP = 32'(card_seq_pkg::STEP_CYCLES);
    localparam logic [31:0] HOLD = 32'(RST_HOLD);
    localparam logic [31:0] LIMIT = 32'(DEADLINE - card_seq_pkg::DEACT_STEPS * (card_seq_pkg::STEP_CYCLES + 1) - 2);
    localparam logic [13:0] REJ_MAX = 14'(card_seq_pkg::DEACT_STEPS * (card_seq_pkg::STEP_CYCLES + 1) + 1);

    function automatic logic in_set(card_seq_pkg::state_type s, logic [12:0] m);
        return |(s & m);
    endfunction

    card_seq_pkg::state_type state_reg;
    card_seq_pkg::state_type state_next;
    logic slot_reg;
    logic slot_next;
    logic volt_next;
    logic switch_reg;
    logic switch_next;
    logic reject_next;
    logic class_reg;
    logic class_next;
    logic stop_ok_reg;
    logic stop_ok_next;
    logic stopped_reg;
    logic stopped_next;
    logic [4:0] byte_reg;
    logic [4:0] byte_next;
    logic [5:0] div_reg;
    logic [5:0] div_next;
    logic clk_next;
    logic [1:0] vcc_next;
    logic step_load;
    logic [31:0] step_count;
    logic step_done;
    logic dl_load;
    logic dl_stop;
    logic dl_expired;
    logic dl_running;
    logic deact_go;
    logic reject_go;
    logic [13:0] reject_age_reg;
    logic [13:0] reject_age_next;

    // ------------------------------------------------------------
    // Step and deadline timers
    // ------------------------------------------------------------
    cycle_timer step_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .load_i(step_load),
        .stop_i(1'b0),
        .count_i(step_count),
        .expired_o(step_done),
        .running_o()
    );

    // R14 deadline counter
    cycle_timer deadline_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .load_i(dl_load),
        .stop_i(dl_stop),
        .count_i(LIMIT),
        .expired_o(dl_expired),
        .running_o(dl_running)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        volt_next = card_vcc_3v_o;
        switch_next = switch_reg;
        reject_next = rejected_o;
        class_next = class_reg;
        stop_ok_next = stop_ok_reg;
        stopped_next = stopped_reg;
        byte_next = byte_reg;
        step_load = 1'b0;
        step_count = STEP;
        dl_load = 1'b0;
        dl_stop = 1'b0;
        deact_go = 1'b0;
        reject_go = 1'b0;
        case (state_reg)
            card_seq_pkg::ST_IDLE: begin
                // R1 one slot, chosen at activation
                if (activate_i) begin
                    slot_next = slot_i;
                    // R9 R11 first supply level
                    volt_next = only_3v_i;
                    switch_next = 1'b0;
                    reject_next = 1'b0;
                    state_next = card_seq_pkg::ST_VCC;
                    step_load = 1'b1;
                end
            end
            // R2 ordered activation
            card_seq_pkg::ST_VCC: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_IO;
                    step_load = 1'b1;
                end
            end
            card_seq_pkg::ST_IO: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_CLK;
                    step_load = 1'b1;
                end
            end
            card_seq_pkg::ST_CLK: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_RST;
                    step_load = 1'b1;
                    step_count = HOLD;
                end
            end
            card_seq_pkg::ST_RST: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_ATR;
                    byte_next = 5'h00;
                    class_next = 1'b0;
                    stop_ok_next = 1'b0;
                end
            end
            card_seq_pkg::ST_ATR: begin
                if (exchange_fail_i) begin
                    reject_go = 1'b1;
                end else if (deactivate_i) begin
                    deact_go = 1'b1;
                end else if (atr_done_i) begin
                    // R8 R14 identification starts the deadline
                    state_next = card_seq_pkg::ST_IDENT;
                    dl_load = 1'b1;
                end
            end
            card_seq_pkg::ST_IDENT: begin
                // R7 class bit from status byte 14
                if (status_valid_i) begin
                    if (byte_reg == card_seq_pkg::CLASS_BYTE - 5'h01) begin
                        class_next = status_byte_i[card_seq_pkg::CLASS_BIT];
                        // R6 clock stop permission
                        stop_ok_next = status_byte_i[card_seq_pkg::CLKSTOP_BIT];
                    end
                    if (byte_reg != 5'h1f) begin
                        byte_next = byte_reg + 5'h01;
                    end
                end
                // R12 reject on failure or deadline
                if (exchange_fail_i || dl_expired) begin
                    reject_go = 1'b1;
                end else if (exchange_done_i && only_3v_i && !class_reg) begin
                    reject_go = 1'b1;
                end else if (exchange_done_i && !only_3v_i && class_reg && prefer_3v_i && !card_vcc_3v_o) begin
                    // R10 R13 switch before any further command
                    switch_next = 1'b1;
                    deact_go = 1'b1;
                end else if (exchange_done_i) begin
                    // R5 T=0 engine takes over the session
                    state_next = card_seq_pkg::ST_RUN;
                    dl_stop = 1'b1;
                end else if (deactivate_i) begin
                    deact_go = 1'b1;
                end
            end
            card_seq_pkg::ST_RUN: begin
                // R4 restart clears the stopped state
                stopped_next = clk_stop_i && stop_ok_reg;
                if (deactivate_i) begin
                    deact_go = 1'b1;
                end
            end
            card_seq_pkg::ST_D_RST: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_D_CLK;
                    step_load = 1'b1;
                end
            end
            card_seq_pkg::ST_D_CLK: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_D_IO;
                    step_load = 1'b1;
                end
            end
            card_seq_pkg::ST_D_IO, card_seq_pkg::ST_FAST: begin
                if (step_done) begin
                    state_next = card_seq_pkg::ST_D_VCC;
                    step_load = 1'b1;
                end
            end
            card_seq_pkg::ST_D_VCC: begin
                if (step_done) begin
                    // R14 deadline ends with deactivation
                    dl_stop = 1'b1;
                    stopped_next = 1'b0;
                    // R13 reactivate at the new level
                    if (switch_reg) begin
                        switch_next = 1'b0;
                        volt_next = 1'b1;
                        state_next = card_seq_pkg::ST_VCC;
                        step_load = 1'b1;
                    end else begin
                        state_next = card_seq_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = card_seq_pkg::ST_IDLE;
            end
        endcase
        if (reject_go) begin
            reject_next = 1'b1;
            switch_next = 1'b0;
        end
        if (reject_go || deact_go) begin
            step_load = 1'b1;
            step_count = STEP;
            // R3 R4 shortcut only while clock still stopped
            if (stopped_reg) begin
                state_next = card_seq_pkg::ST_FAST;
            end else begin
                state_next = card_seq_pkg::ST_D_RST;
            end
        end
    end

    // ------------------------------------------------------------
    // Card clock and contact levels
    // ------------------------------------------------------------
    always_comb begin
        div_next = div_reg + 6'h01;
        clk_next = card_clk_o;
        if (div_reg == card_seq_pkg::CLK_DIV_HALF - 6'h01) begin
            div_next = 6'h00;
            if (in_set(state_next, card_seq_pkg::M_CLK) && !stopped_next) begin
                clk_next = !card_clk_o;
            end else begin
                clk_next = 1'b0;
            end
        end
        vcc_next = 2'b00;
        // R1 supply to the selected slot only
        if (in_set(state_next, card_seq_pkg::M_VCC)) begin
            vcc_next = slot_next ? 2'b10 : 2'b01;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= card_seq_pkg::ST_IDLE;
            slot_reg <= 1'b0;
            switch_reg <= 1'b0;
            class_reg <= 1'b0;
            stop_ok_reg <= 1'b0;
            stopped_reg <= 1'b0;
            byte_reg <= 5'h00;
            div_reg <= 6'h00;
            card_vcc_en_o <= 2'b00;
            card_vcc_3v_o <= 1'b0;
            card_rst_o <= 1'b0;
            card_clk_o <= 1'b0;
            card_io_o <= 1'b0;
            card_io_oe_o <= 1'b1;
            ident_phase_o <= 1'b0;
            session_ready_o <= 1'b0;
            rejected_o <= 1'b0;
            busy_o <= 1'b0;
            class_3v_o <= 1'b0;
            clk_stopped_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            switch_reg <= switch_next;
            class_reg <= class_next;
            stop_ok_reg <= stop_ok_next;
            stopped_reg <= stopped_next;
            byte_reg <= byte_next;
            div_reg <= div_next;
            card_vcc_en_o <= vcc_next;
            card_vcc_3v_o <= volt_next;
            card_rst_o <= in_set(state_next, card_seq_pkg::M_RST);
            card_clk_o <= clk_next;
            card_io_o <= 1'b0;
            card_io_oe_o <= in_set(state_next, card_seq_pkg::M_IOLOW) ||
                (in_set(state_next, card_seq_pkg::M_RST) && io_tx_low_i);
            ident_phase_o <= state_next == card_seq_pkg::ST_IDENT;
            session_ready_o <= state_next == card_seq_pkg::ST_RUN;
            rejected_o <= reject_next;
            busy_o <= state_next != card_seq_pkg::ST_IDLE;
            class_3v_o <= class_next;
            clk_stopped_o <= stopped_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    property p_one_slot;
        $onehot0(card_vcc_en_o);
    endproperty
    a_one_slot: assert property (p_one_slot) else $error("two slots powered"); // R1

    property p_act_order;
        $rose(|card_vcc_en_o) |-> !card_rst_o && !card_clk_o && card_io_oe_o ##1 !card_rst_o [*8];
    endproperty
    a_act_order: assert property (p_act_order) else $error("activation order broken"); // R2

    property p_clk_needs_vcc;
        card_clk_o |-> |card_vcc_en_o;
    endproperty
    a_clk_needs_vcc: assert property (p_clk_needs_vcc) else $error("clock without supply"); // R2

    property p_all_low_off;
        $fell(|card_vcc_en_o) |-> $past(!card_rst_o && !card_clk_o && card_io_oe_o);
    endproperty
    a_all_low_off: assert property (p_all_low_off) else $error("contact high at supply drop"); // R3

    property p_full_deact;
        (state_reg == card_seq_pkg::ST_RUN && deactivate_i && !stopped_reg) |=>
            state_reg == card_seq_pkg::ST_D_RST ##1 card_vcc_en_o != 2'b00;
    endproperty
    a_full_deact: assert property (p_full_deact) else $error("shortcut with running clock"); // R4

    property p_first_5v;
        ($rose(|card_vcc_en_o) && $past(state_reg == card_seq_pkg::ST_IDLE) && !$past(only_3v_i))
            |-> !card_vcc_3v_o;
    endproperty
    a_first_5v: assert property (p_first_5v) else $error("first activation not at 5 V"); // R9

    property p_only_3v;
        ($rose(|card_vcc_en_o) && $past(only_3v_i)) |-> card_vcc_3v_o;
    endproperty
    a_only_3v: assert property (p_only_3v) else $error("3 V-only terminal used 5 V"); // R11

    property p_supply_change;
        $changed(card_vcc_3v_o) |-> $past(card_vcc_en_o) == 2'b00;
    endproperty
    a_supply_change: assert property (p_supply_change) else $error("supply changed while powered"); // R13

    property p_ready_after_ident;
        $rose(session_ready_o) |-> $past(state_reg == card_seq_pkg::ST_IDENT) && $past(exchange_done_i);
    endproperty
    a_ready_after_ident: assert property (p_ready_after_ident) else $error("session before class read"); // R8

    property p_reject;
        (state_reg == card_seq_pkg::ST_IDENT && only_3v_i && exchange_done_i && !class_reg)
            |=> rejected_o && !session_ready_o;
    endproperty
    a_reject: assert property (p_reject) else $error("5 V-only card not rejected"); // R12

    // R12 rejection age
    always_comb begin
        reject_age_next = 14'h0000;
        if (rejected_o && card_vcc_en_o != 2'b00) begin
            reject_age_next = reject_age_reg;
            if (reject_age_reg != 14'h3fff) begin
                reject_age_next = reject_age_reg + 14'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reject_age_reg <= 14'h0000;
        end else begin
            reject_age_reg <= reject_age_next;
        end
    end

    property p_reject_off;
        reject_age_reg <= REJ_MAX;
    endproperty
    a_reject_off: assert property (p_reject_off) else $error("rejected card still powered"); // R12

    property p_deadline_run;
        state_reg == card_seq_pkg::ST_IDENT |-> dl_running || dl_expired;
    endproperty
    a_deadline_run: assert property (p_deadline_run) else $error("deadline not counting"); // R14

    c_session: cover property ($rose(session_ready_o));
    c_switch: cover property ($rose(card_vcc_3v_o) && $past(state_reg == card_seq_pkg::ST_D_VCC));
    c_reject: cover property ($rose(rejected_o));
    c_fast: cover property (state_reg == card_seq_pkg::ST_FAST);
endmodule
`default_nettype wire

// ===== testbench/sim_card_model.sv
`default_nettype none
module sim_card_model (
    input wire logic ref_clk_i,
    input wire logic card_rst_i,
    input wire logic ident_phase_i,
    input wire logic class_3v_i,
    output logic atr_done_o,
    output logic status_valid_o,
    output logic [7:0] status_byte_o,
    output logic exchange_done_o,
    output logic exchange_fail_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Answer-to-reset and status response
    // ------------------------------------------------------------
    initial begin
        atr_done_o = 1'b0;
        status_valid_o = 1'b0;
        status_byte_o = 8'hff;
        exchange_done_o = 1'b0;
        exchange_fail_o = 1'b0;
        forever begin
            @(posedge card_rst_i);
            repeat (40) @(posedge ref_clk_i);
            #1 atr_done_o = 1'b1;
            @(posedge ref_clk_i);
            #1 atr_done_o = 1'b0;
            while (ident_phase_i !== 1'b1) @(posedge ref_clk_i);
            for (int b = 1; b <= 14; b++) begin
                repeat (3) @(posedge ref_clk_i);
                #1 status_valid_o = 1'b1;
                status_byte_o = (b == 14) ? {2'h0, class_3v_i, 4'h0, 1'b1} : 8'h10 + 8'(b);
                @(posedge ref_clk_i);
                #1 status_valid_o = 1'b0;
                status_byte_o = ~status_byte_o;
            end
            repeat (3) @(posedge ref_clk_i);
            #1 exchange_done_o = 1'b1;
            @(posedge ref_clk_i);
            #1 exchange_done_o = 1'b0;
            wait (card_rst_i !== 1'b1);
        end
    end
endmodule
`default_nettype wire

// ===== testbench/smart_card_voltage_class_sequencer_test.sv
`default_nettype none
module smart_card_voltage_class_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STEP = card_seq_pkg::STEP_CYCLES;
    logic clk = 1'b0, rst = 1'b1, act = 1'b0, deact = 1'b0, slot = 1'b0, only3 = 1'b0, pref3 = 1'b0;
    logic cstop = 1'b0, card_cls = 1'b1;
    logic atr, sval, xdone, xfail, rdy, rej, busy, cls, cstopped, vcc3, crst, cclk, cio, cio_oe, ident;
    logic [7:0] sbyte;
    logic [1:0] vcc;
    int n_mismatch = 0, tests_run = 0, cycles = 0, n;
    logic seen_off, seen_rdy;
    always #2 clk = ~clk;
    card_supply_sequencer #(.RST_HOLD(64), .DEADLINE(20000)) dut_u (
        .ref_clk_i(clk), .reset_i(rst), .activate_i(act), .deactivate_i(deact), .slot_i(slot),
        .only_3v_i(only3), .prefer_3v_i(pref3), .clk_stop_i(cstop), .atr_done_i(atr),
        .status_valid_i(sval), .status_byte_i(sbyte), .exchange_done_i(xdone), .exchange_fail_i(xfail),
        .io_tx_low_i(1'b0), .card_vcc_en_o(vcc), .card_vcc_3v_o(vcc3), .card_rst_o(crst),
        .card_clk_o(cclk), .card_io_o(cio), .card_io_oe_o(cio_oe), .ident_phase_o(ident),
        .session_ready_o(rdy), .rejected_o(rej), .busy_o(busy), .class_3v_o(cls), .clk_stopped_o(cstopped));
    sim_card_model card_u (.ref_clk_i(clk), .card_rst_i(crst), .ident_phase_i(ident), .class_3v_i(card_cls),
        .atr_done_o(atr), .status_valid_o(sval), .status_byte_o(sbyte), .exchange_done_o(xdone),
        .exchange_fail_o(xfail));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic bit cond(input int k);
        case (k)
            0: return rdy === 1'b1;
            1: return vcc === 2'b00;
            2: return cio_oe === 1'b0;
            3: return cio_oe === 1'b1;
            4: return rej === 1'b1;
            default: return busy === 1'b0;
        endcase
    endfunction
    task automatic wait_for(input int k, input int lim);
        n = 0;
        while (!cond(k) && n < lim) begin
            @(posedge clk);
            #1 n++;
            if (vcc === 2'b00) seen_off = 1'b1;
            if (rdy === 1'b1) seen_rdy = 1'b1;
        end
        check(16'(cond(k)), 16'h0001);
    endtask
    task automatic start(input logic s, input logic o3, input logic p3, input logic c);
        seen_off = 1'b0;
        seen_rdy = 1'b0;
        card_cls = c;
        slot = s;
        only3 = o3;
        pref3 = p3;
        act = 1'b1;
        @(posedge clk);
        #1 act = 1'b0;
        @(posedge clk);
        #1 check({busy, vcc3, 12'h000, vcc}, {1'b1, o3, 12'h000, s, ~s});
        wait_for(2, STEP + 2);
        check({crst, cclk, 14'h0000}, 16'h0000);
    endtask
    task automatic stop_card(input int lim);
        deact = 1'b1;
        @(posedge clk);
        #1 deact = 1'b0;
        wait_for(1, lim);
        check({13'h0000, crst, cclk, cio_oe}, 16'h0001);
        wait_for(5, STEP + 2);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_stopped_shortcut();
        start(1'b0, 1'b0, 1'b0, 1'b1);
        wait_for(0, 20000);
        check({vcc3, cls, 14'h0000}, 16'h4000);
        cstop = 1'b1;
        repeat (80) @(posedge clk);
        #1 check({cstopped, cclk, 14'h0000}, 16'h8000);
        stop_card(2 * STEP + 4);
        cstop = 1'b0;
        $display("test stopped shortcut done");
    endtask
    task automatic test_ordered_slot1();
        start(1'b1, 1'b0, 1'b0, 1'b1);
        wait_for(0, 20000);
        cstop = 1'b1;
        repeat (80) @(posedge clk);
        #1 cstop = 1'b0;
        repeat (80) @(posedge clk);
        #1 check({cstopped, 15'h0000}, 16'h0000);
        deact = 1'b1;
        @(posedge clk);
        #1 deact = 1'b0;
        wait_for(3, 3 * STEP + 4);
        check({cclk, crst, 12'h000, vcc}, 16'h0002);
        check(16'(n > 2 * STEP - 4), 16'h0001);
        wait_for(1, STEP + 4);
        wait_for(5, STEP + 2);
        $display("test ordered slot1 done");
    endtask
    task automatic test_switch_to_3v();
        start(1'b0, 1'b0, 1'b1, 1'b1);
        wait_for(0, 40000);
        check({vcc3, seen_off, 12'h000, vcc}, 16'hc001);
        stop_card(4 * STEP + 4);
        $display("test switch to 3v done");
    endtask
    task automatic test_reject_5v_card();
        start(1'b0, 1'b1, 1'b0, 1'b0);
        wait_for(4, 20000);
        wait_for(1, 4 * STEP + 2);
        check({seen_rdy, cls, 14'h0000}, 16'h0000);
        wait_for(5, STEP + 2);
        check({rej, 15'h0000}, 16'h8000);
        $display("test reject 5v card done");
    endtask
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check({9'h000, cio, vcc, crst, cclk, cio_oe, busy}, 16'h0002);
        test_stopped_shortcut();
        test_ordered_slot1();
        test_switch_to_3v();
        test_reject_5v_card();
        report_and_stop();
    end
endmodule
`default_nettype wire
